// ===== logic/apso_top.sv
`timescale 1ns/1ps
`default_nettype none
module apso_top
  import apso_pkg::*;
#(
  parameter int STEP_DIV = STEP_DIV_DEF,
  parameter int DECEL_N  = DECEL_PULSES
) (
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  input  wire logic       i_wr_en,
  input  wire logic [1:0] i_wr_axis,
  input  wire logic [1:0] i_wr_sel,
  input  wire logic [7:0] i_wr_data,
  input  wire logic [3:0] i_drive_start,
  input  wire logic [3:0] i_drive_dir,
  input  wire logic [3:0] i_drive_ramp,
  input  wire logic [3:0] i_compare_plus,
  input  wire logic [3:0] i_compare_minus,
  input  wire logic [3:0] i_limit_plus_in,
  input  wire logic [3:0] i_limit_minus_in,
  input  wire logic [3:0] i_index_phase_in,
  input  wire logic [3:0] i_near_origin_in_one,
  input  wire logic [3:0] i_near_origin_in_two,
  input  wire logic [3:0] i_near_origin_in_three,
  output logic      [3:0] o_cw_pulse_true,
  output logic      [3:0] o_cw_pulse_comp,
  output logic      [3:0] o_ccw_dir_true,
  output logic      [3:0] o_ccw_dir_comp,
  output logic      [3:0] o_gp_out_ch4,
  output logic      [3:0] o_gp_out_ch5,
  output logic      [3:0] o_servo_on_out,
  output logic      [3:0] o_drive_reset_out,
  output logic      [3:0] o_driving,
  output logic      [3:0] o_stop_limit,
  output logic      [3:0] o_stop_near,
  output logic      [7:0] o_input_status_one,
  output logic      [7:0] o_input_status_two
);
  // ==========================================================
  // Pin synchronisers
  logic [PIN_INS-1:0] pin_raw;
  logic [PIN_INS-1:0] pin_sync;
  logic [3:0]         lim_plus_s;
  logic [3:0]         lim_minus_s;
  logic [3:0]         index_s;
  logic [3:0]         near_one_s;
  logic [3:0]         near_two_s;
  logic [3:0]         near_three_s;

  assign pin_raw = {i_near_origin_in_three, i_near_origin_in_two, i_near_origin_in_one,
                    i_index_phase_in, i_limit_minus_in, i_limit_plus_in};

  apso_sync #(
    .W       (PIN_INS),
    .RST_VAL (PIN_RST)
  ) u_sync (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_async   (pin_raw),
    .o_sync    (pin_sync)
  );

  assign lim_plus_s   = pin_sync[3:0];
  assign lim_minus_s  = pin_sync[7:4];
  assign index_s      = pin_sync[11:8];
  assign near_one_s   = pin_sync[15:12];
  assign near_two_s   = pin_sync[19:16];
  assign near_three_s = pin_sync[23:20];

  // ==========================================================
  // Write decode
  logic [3:0] wr_one;
  logic [3:0] wr_two;
  logic [3:0] wr_gp;
  logic [3:0] wr_cfg;

  genvar a;
  generate
    for (a = 0; a < AXES; a++) begin : g_dec
      wire axis_hit = i_wr_en & (i_wr_axis == 2'(a));
      assign wr_one[a] = axis_hit & (i_wr_sel == WSEL_REG_ONE);
      assign wr_two[a] = axis_hit & (i_wr_sel == WSEL_REG_TWO);
      assign wr_gp[a]  = axis_hit & (i_wr_sel == WSEL_GP_OUT);
      assign wr_cfg[a] = axis_hit & (i_wr_sel == WSEL_CFG);
    end
  endgenerate

  // ==========================================================
  // Per-axis control registers
  logic [7:0] reg_one_r [AXES];
  logic [7:0] reg_two_r [AXES];
  logic [7:0] gp_r      [AXES];
  logic [7:0] cfg_r     [AXES];

  always_ff @(posedge i_ref_clk) begin
    for (int i = 0; i < AXES; i++) begin
      if (i_rst) begin
        reg_one_r[i] <= REG_ONE_RST;
        reg_two_r[i] <= REG_TWO_RST;
        gp_r[i]      <= GP_OUT_RST;
        cfg_r[i]     <= CFG_RST;
      end else begin
        if (wr_one[i]) reg_one_r[i] <= i_wr_data;
        if (wr_two[i]) reg_two_r[i] <= i_wr_data;
        if (wr_gp[i])  gp_r[i]      <= i_wr_data;
        if (wr_cfg[i]) cfg_r[i]     <= i_wr_data;
      end
    end
  end

  // ==========================================================
  // Step rate divider
  logic [15:0] div_cnt_r;
  logic        tick_r;
  wire         div_wrap = (div_cnt_r == 16'(STEP_DIV - 1));

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      div_cnt_r <= 16'h0000;
      tick_r    <= 1'h0;
    end else begin
      div_cnt_r <= div_wrap ? 16'h0000 : div_cnt_r + 16'h0001;
      tick_r    <= div_wrap;
    end
  end

  // ==========================================================
  // Stop decisions and drive engines
  logic [3:0] hard_stop;
  logic [3:0] soft_stop;
  logic [3:0] step_w;
  logic [3:0] driving_w;
  logic [3:0] dir_w;
  logic [3:0] cw_nxt;
  logic [3:0] ccw_nxt;
  logic [3:0] pin4_nxt;
  logic [3:0] pin5_nxt;
  logic [3:0] servo_nxt;
  logic [3:0] dreset_nxt;
  logic [3:0] near_nib [AXES];

  generate
    for (a = 0; a < AXES; a++) begin : g_axis
      apso_drv_if dif ();
      logic [NEAR_INS-1:0] near_lvl;
      logic [NEAR_INS-1:0] near_hit;
      wire                 limit_lvl = reg_two_r[a][REG2_LIMIT_LVL];
      wire                 lim_p_act = (lim_plus_s[a] == limit_lvl);
      wire                 lim_m_act = (lim_minus_s[a] == limit_lvl);
      wire                 pulse_dir = cfg_r[a][CFG_PULSE_DIR];
      wire                 low_bank  = cfg_r[a][CFG_GP_LOW_BANK];
      wire                 cmp_route = cfg_r[a][CFG_CMP_ROUTE] & low_bank;

      assign near_lvl    = {near_three_s[a], near_two_s[a], near_one_s[a], index_s[a]};
      assign near_nib[a] = near_lvl;

      genvar k;
      for (k = 0; k < NEAR_INS; k++) begin : g_near
        // Enable in the odd bit, active level in the even bit
        assign near_hit[k] = reg_one_r[a][2*k+1] &
                             (near_lvl[k] == reg_one_r[a][2*k]);
      end

      assign hard_stop[a] = (dif.driving ? dif.dir_q : i_drive_dir[a]) ? lim_m_act : lim_p_act;
      assign soft_stop[a] = |near_hit;

      assign dif.start     = i_drive_start[a];
      assign dif.dir       = i_drive_dir[a];
      assign dif.ramp      = i_drive_ramp[a];
      assign dif.tick      = tick_r;
      assign dif.hard_stop = hard_stop[a];
      assign dif.soft_stop = soft_stop[a];
      assign step_w[a]     = dif.step;
      assign driving_w[a]  = dif.driving;
      assign dir_w[a]      = dif.dir_q;

      apso_axis_drive #(
        .DECEL_N (DECEL_N)
      ) u_drive (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .bus       (dif)
      );

      // Pulse pair formatting
      assign cw_nxt[a]  = pulse_dir ? step_w[a] : (step_w[a] & ~dir_w[a]);
      assign ccw_nxt[a] = pulse_dir ? dir_w[a]  : (step_w[a] &  dir_w[a]);

      // Connector channel selection
      assign pin4_nxt[a]   = cmp_route ? i_compare_plus[a]  : gp_r[a][GP_CH4];
      assign pin5_nxt[a]   = cmp_route ? i_compare_minus[a] : gp_r[a][GP_CH5];
      assign servo_nxt[a]  = low_bank  ? gp_r[a][GP_CH2] : gp_r[a][GP_CH6];
      assign dreset_nxt[a] = low_bank  ? gp_r[a][GP_CH3] : gp_r[a][GP_CH7];
    end
  endgenerate

  // ==========================================================
  // Registered pulse outputs
  logic [3:0] cw_true_r;
  logic [3:0] cw_comp_r;
  logic [3:0] ccw_true_r;
  logic [3:0] ccw_comp_r;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      cw_true_r  <= 4'h0;
      cw_comp_r  <= 4'hF;
      ccw_true_r <= 4'h0;
      ccw_comp_r <= 4'hF;
    end else begin
      cw_true_r  <= cw_nxt;
      cw_comp_r  <= ~cw_nxt;
      ccw_true_r <= ccw_nxt;
      ccw_comp_r <= ~ccw_nxt;
    end
  end

  // ==========================================================
  // Registered general outputs
  logic [3:0] pin4_r;
  logic [3:0] pin5_r;
  logic [3:0] servo_r;
  logic [3:0] dreset_r;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      pin4_r   <= 4'h0;
      pin5_r   <= 4'h0;
      servo_r  <= 4'h0;
      dreset_r <= 4'h0;
    end else begin
      pin4_r   <= pin4_nxt;
      pin5_r   <= pin5_nxt;
      servo_r  <= servo_nxt;
      dreset_r <= dreset_nxt;
    end
  end

  // ==========================================================
  // Drive status and stop causes
  logic [3:0] driving_r;
  logic [3:0] stop_limit_r;
  logic [3:0] stop_near_r;
  wire  [3:0] limit_set = driving_w & hard_stop;
  wire  [3:0] near_set  = driving_w & soft_stop;
  wire  [3:0] cause_clr = i_drive_start & ~driving_w & ~hard_stop;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      driving_r    <= 4'h0;
      stop_limit_r <= 4'h0;
      stop_near_r  <= 4'h0;
    end else begin
      driving_r    <= driving_w;
      // Set wins over the clear of a new start
      stop_limit_r <= (stop_limit_r & ~cause_clr) | limit_set;
      stop_near_r  <= (stop_near_r  & ~cause_clr) | near_set;
    end
  end

  // ==========================================================
  // Input status registers
  logic [7:0] status_one_r;
  logic [7:0] status_two_r;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      status_one_r <= 8'hFF;
      status_two_r <= 8'hFF;
    end else begin
      status_one_r <= {near_nib[1], near_nib[0]};
      status_two_r <= {near_nib[3], near_nib[2]};
    end
  end

  // ==========================================================
  // Output ports
  assign o_cw_pulse_true    = cw_true_r;
  assign o_cw_pulse_comp    = cw_comp_r;
  assign o_ccw_dir_true     = ccw_true_r;
  assign o_ccw_dir_comp     = ccw_comp_r;
  assign o_gp_out_ch4       = pin4_r;
  assign o_gp_out_ch5       = pin5_r;
  assign o_servo_on_out     = servo_r;
  assign o_drive_reset_out  = dreset_r;
  assign o_driving          = driving_r;
  assign o_stop_limit       = stop_limit_r;
  assign o_stop_near        = stop_near_r;
  assign o_input_status_one = status_one_r;
  assign o_input_status_two = status_two_r;
endmodule
`default_nettype wire

// ===== logic/apso_pkg.sv
`default_nettype none
package apso_pkg;
  // ==========================================================
  // Geometry
  localparam int AXES        = 4;
  localparam int NEAR_INS    = 4;
  localparam int PIN_INS     = 24;
  // ==========================================================
  // Write port selects
  localparam logic [1:0] WSEL_REG_ONE = 2'h0;
  localparam logic [1:0] WSEL_REG_TWO = 2'h1;
  localparam logic [1:0] WSEL_GP_OUT  = 2'h2;
  localparam logic [1:0] WSEL_CFG     = 2'h3;
  // ==========================================================
  // Field positions
  localparam int REG2_LIMIT_LVL  = 3;
  localparam int CFG_PULSE_DIR   = 0;
  localparam int CFG_GP_LOW_BANK = 1;
  localparam int CFG_CMP_ROUTE   = 2;
  localparam int GP_CH2          = 2;
  localparam int GP_CH3          = 3;
  localparam int GP_CH4          = 4;
  localparam int GP_CH5          = 5;
  localparam int GP_CH6          = 6;
  localparam int GP_CH7          = 7;
  // ==========================================================
  // Reset values
  localparam logic [7:0] REG_ONE_RST = 8'h00;
  localparam logic [7:0] REG_TWO_RST = 8'h00;
  localparam logic [7:0] GP_OUT_RST  = 8'h00;
  localparam logic [7:0] CFG_RST     = 8'h00;
  localparam logic [PIN_INS-1:0] PIN_RST = 24'hFFFFFF;
  // ==========================================================
  // Timing
  localparam longint CLK_HZ       = 200_000_000;
  localparam longint STEP_HZ      = 1_000_000;
  localparam int     STEP_DIV_DEF = int'(CLK_HZ / STEP_HZ);
  localparam int     DECEL_PULSES = 8;
  // ==========================================================
  // Drive states
  typedef enum logic [2:0] {
    DRV_IDLE  = 3'b001,
    DRV_RUN   = 3'b010,
    DRV_DECEL = 3'b100
  } apso_drv_state_t;
endpackage
`default_nettype wire

// ===== logic/apso_drv_if.sv
`timescale 1ns/1ps
`default_nettype none
interface apso_drv_if;
  logic start;
  logic dir;
  logic ramp;
  logic tick;
  logic hard_stop;
  logic soft_stop;
  logic step;
  logic driving;
  logic dir_q;
  modport ctl (output start, dir, ramp, tick, hard_stop, soft_stop,
               input  step, driving, dir_q);
  modport drv (input  start, dir, ramp, tick, hard_stop, soft_stop,
               output step, driving, dir_q);
endinterface
`default_nettype wire

// ===== logic/apso_sync.sv
`timescale 1ns/1ps
`default_nettype none
module apso_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = {W{1'h0}}
) (
  input  wire logic         i_ref_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  // ==========================================================
  // Three stages, accept when second and third agree
  genvar b;
  generate
    for (b = 0; b < W; b++) begin : g_bit
      logic [2:0] st_r;
      logic       q_r;
      always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
          st_r <= {3{RST_VAL[b]}};
          q_r  <= RST_VAL[b];
        end else begin
          st_r <= {st_r[1:0], i_async[b]};
          if (st_r[2] == st_r[1]) begin
            q_r <= st_r[2];
          end
        end
      end
      assign o_sync[b] = q_r;
    end
  endgenerate
endmodule
`default_nettype wire

// ===== logic/apso_axis_drive.sv
`timescale 1ns/1ps
`default_nettype none
module apso_axis_drive
  import apso_pkg::*;
#(
  parameter int DECEL_N = DECEL_PULSES
) (
  input  wire logic i_ref_clk,
  input  wire logic i_rst,
  apso_drv_if.drv   bus
);
  apso_drv_state_t state_r;
  apso_drv_state_t state_nxt;
  logic       phase_r;
  logic       slow_r;
  logic       step_r;
  logic       dir_r;
  logic [7:0] left_r;
  wire        in_decel  = (state_r == DRV_DECEL);
  wire        eff_tick  = bus.tick & (~in_decel | slow_r);
  wire        pulse_end = eff_tick & phase_r;
  wire        cut_now   = bus.hard_stop | (bus.soft_stop & ~bus.ramp);
  // ==========================================================
  // Drive sequencing
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      DRV_IDLE: begin
        if (bus.start && !bus.hard_stop) state_nxt = DRV_RUN;
      end
      DRV_RUN: begin
        if (cut_now) state_nxt = DRV_IDLE;
        else if (bus.soft_stop) state_nxt = DRV_DECEL;
      end
      DRV_DECEL: begin
        if (bus.hard_stop || (pulse_end && left_r == 8'h00)) state_nxt = DRV_IDLE;
      end
      default: state_nxt = DRV_IDLE;
    endcase
  end
  // ==========================================================
  // Step timing, half rate while slowing down
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      state_r <= DRV_IDLE;
      phase_r <= 1'h0;
      slow_r  <= 1'h0;
      step_r  <= 1'h0;
      dir_r   <= 1'h0;
      left_r  <= 8'h00;
    end else begin
      state_r <= state_nxt;
      if (state_nxt == DRV_IDLE || state_r == DRV_IDLE) begin
        phase_r <= 1'h0;
        slow_r  <= 1'h0;
        step_r  <= 1'h0;
        left_r  <= 8'(DECEL_N);
        if (state_nxt == DRV_RUN) dir_r <= bus.dir;
      end else begin
        if (in_decel && bus.tick) slow_r <= ~slow_r;
        if (eff_tick) begin
          phase_r <= ~phase_r;
          step_r  <= ~phase_r;
        end
        if (eff_tick && !phase_r && in_decel) left_r <= left_r - 8'h01;
      end
    end
  end
  assign bus.step    = step_r;
  assign bus.driving = (state_r != DRV_IDLE);
  assign bus.dir_q   = dir_r;
endmodule
`default_nettype wire

// ===== dv/apso_motor_model.sv
`timescale 1ns/1ps
`default_nettype none
module apso_motor_model (
  input  wire logic        i_ref_clk,
  input  wire logic        i_clr,
  input  wire logic [3:0]  i_cw,
  input  wire logic [3:0]  i_ccw,
  input  wire logic [23:0] i_press,
  output logic      [23:0] o_pin,
  output logic [3:0][7:0]  o_cw_cnt,
  output logic [3:0][7:0]  o_ccw_cnt
);
  logic [3:0] cw_q;
  logic [3:0] ccw_q;
  // ==========================================================
  // Switches pull their line low when applied
  assign o_pin = ~i_press;
  // ==========================================================
  // Drive side counts rising pulse edges
  always_ff @(posedge i_ref_clk) begin
    cw_q  <= i_cw;
    ccw_q <= i_ccw;
    for (int a = 0; a < 4; a++) begin
      if (i_clr) begin
        o_cw_cnt[a]  <= 8'h00;
        o_ccw_cnt[a] <= 8'h00;
      end else begin
        o_cw_cnt[a]  <= o_cw_cnt[a] + 8'(i_cw[a] & ~cw_q[a]);
        o_ccw_cnt[a] <= o_ccw_cnt[a] + 8'(i_ccw[a] & ~ccw_q[a]);
      end
    end
  end
endmodule
`default_nettype wire

// ===== dv/apso_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
module apso_top_sva (
  input wire logic       i_ref_clk,
  input wire logic       i_rst,
  input wire logic [3:0] i_drive_ramp,
  input wire logic [3:0] i_index_phase_in,
  input wire logic [3:0] i_near_origin_in_three,
  input wire logic [3:0] o_cw_pulse_true,
  input wire logic [3:0] o_cw_pulse_comp,
  input wire logic [3:0] o_ccw_dir_true,
  input wire logic [3:0] o_ccw_dir_comp,
  input wire logic [3:0] o_gp_out_ch4,
  input wire logic [3:0] o_gp_out_ch5,
  input wire logic [3:0] o_servo_on_out,
  input wire logic [3:0] o_drive_reset_out,
  input wire logic [3:0] o_driving,
  input wire logic [3:0] o_stop_limit,
  input wire logic [3:0] o_stop_near,
  input wire logic [7:0] o_input_status_one,
  input wire logic [7:0] o_input_status_two
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  // ==========================================================
  // Sequences
  sequence s_out_rst;
    o_cw_pulse_true == 4'h0 && o_ccw_dir_true == 4'h0;
  endsequence
  sequence s_drive_end;
    ##[0:3] !o_driving[0];
  endsequence
  // ==========================================================
  // Assertions
  comp_pair_a: assert property (o_cw_pulse_comp == ~o_cw_pulse_true)
    else $error("first pair complement wrong");
  ccw_pair_a: assert property (o_ccw_dir_comp == ~o_ccw_dir_true)
    else $error("second pair complement wrong");
  reset_pulse_a: assert property ($fell(i_rst) |-> s_out_rst)
    else $error("pulse lines not low after reset");
  reset_gp_a: assert property ($fell(i_rst) |->
    {o_gp_out_ch4, o_gp_out_ch5, o_servo_on_out, o_drive_reset_out} == 16'h0000)
    else $error("general outputs on after reset");
  reset_idle_a: assert property ($fell(i_rst) |->
    (o_driving | o_stop_near | o_stop_limit) == 4'h0)
    else $error("drive or stop flag after reset");
  limit_cut_a: assert property ($rose(o_stop_limit[0]) |-> s_drive_end)
    else $error("limit stop did not end drive");
  near_cut_a: assert property ($rose(o_stop_near[0]) && !i_drive_ramp[0] |-> s_drive_end)
    else $error("constant speed near stop not immediate");
  pulse_gate_a: assert property ($rose(o_cw_pulse_true[0]) |-> ##[0:1] o_driving[0])
    else $error("pulse outside drive");
  stat_sync_a: assert property ($changed(o_input_status_one[3]) |->
    o_input_status_one[3] == $past(i_near_origin_in_three[0], 2))
    else $error("status follows pin too fast");
  stat_map_a: assert property ($changed(o_input_status_two[4]) |->
    o_input_status_two[4] == $past(i_index_phase_in[3], 2))
    else $error("status bit mapping wrong");
endmodule
bind apso_top apso_top_sva apso_top_sva_i (
  .i_ref_clk, .i_rst, .i_drive_ramp, .i_index_phase_in, .i_near_origin_in_three,
  .o_cw_pulse_true, .o_cw_pulse_comp, .o_ccw_dir_true, .o_ccw_dir_comp,
  .o_gp_out_ch4, .o_gp_out_ch5, .o_servo_on_out, .o_drive_reset_out, .o_driving,
  .o_stop_limit, .o_stop_near, .o_input_status_one, .o_input_status_two
);
`default_nettype wire

// ===== dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import apso_pkg::*;
  localparam int DN = 2;
  logic            i_ref_clk = 1'b0;
  logic            i_rst = 1'b1;
  logic            i_wr_en = 1'b0;
  logic [1:0]      i_wr_axis = 2'h0;
  logic [1:0]      i_wr_sel = 2'h0;
  logic [7:0]      i_wr_data = 8'h00;
  logic [3:0]      i_drive_start = 4'h0;
  logic [3:0]      i_drive_dir = 4'h0;
  logic [3:0]      i_drive_ramp = 4'h0;
  logic [3:0]      i_compare_plus = 4'h1;
  logic [3:0]      i_compare_minus = 4'h0;
  logic [23:0]     press = 24'h000000;
  logic            clr = 1'b1;
  wire  [23:0]     pin;
  logic [3:0][7:0] cw_cnt, ccw_cnt;
  logic [3:0]      o_cw_pulse_true, o_cw_pulse_comp, o_ccw_dir_true, o_ccw_dir_comp;
  logic [3:0]      o_gp_out_ch4, o_gp_out_ch5, o_servo_on_out, o_drive_reset_out;
  logic [3:0]      o_driving, o_stop_limit, o_stop_near;
  logic [7:0]      o_input_status_one, o_input_status_two;
  int              err_total = 0;
  int              n_compared = 0;
  logic [1:0]      t_sel [5] = '{WSEL_GP_OUT, WSEL_GP_OUT, WSEL_CFG, WSEL_GP_OUT, WSEL_CFG};
  logic [7:0]      t_dat [5] = '{8'hF0, 8'h0C, 8'h02, 8'h20, 8'h06};
  logic [3:0]      t_exp [5] = '{4'hF, 4'h0, 4'h3, 4'h4, 4'h8};
  logic [7:0]      c0;
  always #2.5 i_ref_clk = ~i_ref_clk;
  apso_top #(.STEP_DIV(4), .DECEL_N(DN)) apso_top_i (
    .i_ref_clk, .i_rst, .i_wr_en, .i_wr_axis, .i_wr_sel, .i_wr_data, .i_drive_start,
    .i_drive_dir, .i_drive_ramp, .i_compare_plus, .i_compare_minus,
    .i_limit_plus_in(pin[3:0]), .i_limit_minus_in(pin[7:4]), .i_index_phase_in(pin[11:8]),
    .i_near_origin_in_one(pin[15:12]), .i_near_origin_in_two(pin[19:16]),
    .i_near_origin_in_three(pin[23:20]), .o_cw_pulse_true, .o_cw_pulse_comp,
    .o_ccw_dir_true, .o_ccw_dir_comp, .o_gp_out_ch4, .o_gp_out_ch5, .o_servo_on_out,
    .o_drive_reset_out, .o_driving, .o_stop_limit, .o_stop_near, .o_input_status_one,
    .o_input_status_two);
  apso_motor_model apso_motor_model_i (.i_ref_clk, .i_clr(clr), .i_cw(o_cw_pulse_true),
    .i_ccw(o_ccw_dir_true), .i_press(press), .o_pin(pin), .o_cw_cnt(cw_cnt),
    .o_ccw_cnt(ccw_cnt));
  // ==========================================================
  // Tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask
  task automatic wr(input logic [1:0] ax, input logic [1:0] sel, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_wr_en <= 1'b1;
    i_wr_axis <= ax;
    i_wr_sel <= sel;
    i_wr_data <= d;
    @(posedge i_ref_clk);
    i_wr_en <= 1'b0;
    cyc(3);
  endtask
  task automatic drive(input int ax, input logic d, input logic r);
    @(posedge i_ref_clk);
    clr <= 1'b1;
    i_drive_dir[ax] <= d;
    i_drive_ramp[ax] <= r;
    i_drive_start[ax] <= 1'b1;
    @(posedge i_ref_clk);
    clr <= 1'b0;
    i_drive_start[ax] <= 1'b0;
    cyc(6);
  endtask
  task automatic wait_drv(input int ax, input logic lvl);
    int n;
    n = 0;
    while (o_driving[ax] !== lvl && n < 400) begin
      cyc(1);
      n++;
    end
    chk(o_driving[ax], lvl);
  endtask
  task automatic do_reset;
    @(posedge i_ref_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    clr <= 1'b0;
    cyc(1);
    chk({o_cw_pulse_true, o_ccw_dir_true, o_cw_pulse_comp, o_ccw_dir_comp}, 16'h00FF);
    chk({o_gp_out_ch4, o_gp_out_ch5, o_servo_on_out, o_drive_reset_out}, 16'h0);
    chk({o_input_status_two, o_input_status_one}, 16'hFFFF);
  endtask
  task automatic end_sim;
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ==========================================================
  // Sequence of tests
  initial begin
    do_reset();
    wr(2'h0, WSEL_REG_TWO, 8'h00);
    drive(0, 1'b0, 1'b0);
    wait_drv(0, 1'b1);
    cyc(40);
    press[0] <= 1'b1;
    wait_drv(0, 1'b0);
    chk({o_stop_limit[0], cw_cnt[0] != 0, ccw_cnt[0]}, 16'h0300);
    drive(0, 1'b0, 1'b0);
    chk({o_driving[0], o_stop_limit[0]}, 16'h0001);
    press[0] <= 1'b0;
    cyc(6);
    drive(0, 1'b1, 1'b0);
    press[20] <= 1'b1;
    cyc(30);
    chk(o_driving[0], 1'b1);
    wr(2'h0, WSEL_REG_ONE, 8'h80);
    wait_drv(0, 1'b0);
    chk({o_stop_near[0], cw_cnt[0], ccw_cnt[0] != 0}, 16'h0201);
    chk({o_cw_pulse_true[0], o_ccw_dir_true[0]}, 16'h0);
    press[20] <= 1'b0;
    wr(2'h1, WSEL_CFG, 8'h01);
    drive(1, 1'b1, 1'b0);
    cyc(40);
    press[5] <= 1'b1;
    wait_drv(1, 1'b0);
    chk({o_ccw_dir_true[1], cw_cnt[1] != 0, ccw_cnt[1]}, 16'h0301);
    drive(1, 1'b1, 1'b0);
    chk(o_driving[1], 1'b0);
    press[5] <= 1'b0;
    wr(2'h2, WSEL_REG_ONE, 8'h08);
    drive(2, 1'b0, 1'b1);
    cyc(20);
    press[14] <= 1'b1;
    for (int n = 0; n < 200 && o_stop_near[2] !== 1'b1; n++) cyc(1);
    cyc(2);
    c0 = cw_cnt[2];
    wait_drv(2, 1'b0);
    chk(16'(cw_cnt[2] - c0), DN);
    press[14] <= 1'b0;
    wr(2'h3, WSEL_REG_TWO, 8'h08);
    drive(3, 1'b0, 1'b0);
    chk(o_driving[3], 1'b0);
    for (int k = 0; k < 5; k++) begin
      wr(2'h0, t_sel[k], t_dat[k]);
      chk({o_gp_out_ch4[0], o_gp_out_ch5[0], o_servo_on_out[0], o_drive_reset_out[0]},
          t_exp[k]);
    end
    press[11] <= 1'b1;
    press[17] <= 1'b1;
    cyc(8);
    chk({o_input_status_two, o_input_status_one}, 16'hEFBF);
    press <= 24'h000000;
    cyc(8);
    do_reset();
    end_sim();
  end
  initial begin
    repeat (20000) @(posedge i_ref_clk);
    err_total++;
    $display("[ERR] %0t run did not finish in time", $time);
    end_sim();
  end
endmodule
`default_nettype wire
